// >>> clkctl_pkg.sv
// constants, types and register map for the clock output control block
// assumes one 100 MHz core clock and 8-bit configuration bytes
package clkctl_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int DRV_PD_US = 300;
  localparam int DRV_PD_CYC = DRV_PD_US * CLK_MHZ;
  localparam int NUM_PAIRS = 4;

  // ----------------------------------------------------------------
  // smbus addresses picked by the latched select pin
  // ----------------------------------------------------------------
  localparam logic [6:0] SMB_ADDR_LOW = 7'h68;
  localparam logic [6:0] SMB_ADDR_HIGH = 7'h6A;

  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_PAIR_OE = 4'h2;
  localparam logic [3:0] REG_REF_CFG = 4'h3;
  localparam logic [3:0] REG_SPREAD = 4'h5;
  localparam logic [3:0] REG_STOP_STATE = 4'hB;
  localparam logic [3:0] REG_STATUS = 4'hC;
  localparam logic [3:0] REG_SMB_ADDR = 4'hD;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int REF_DIS_RUN_BIT = 4;
  localparam int REF_RUN_IN_POWERDOWN_BIT = 5;
  localparam int SPREAD_OVR_BIT = 2;
  localparam logic [3:0] PAIR_OE_RST = 4'hF;
  localparam logic [7:0] REF_CFG_RST = 8'h00;
  localparam logic [1:0] STOP_STATE_RST = 2'h0;
  localparam logic [2:0] SPREAD_REG_RST = 3'h0;

  // ----------------------------------------------------------------
  // spread codes sent to the pll
  // ----------------------------------------------------------------
  localparam logic [1:0] SPREAD_OFF = 2'h0;
  localparam logic [1:0] SPREAD_QUARTER = 2'h1;
  localparam logic [1:0] SPREAD_HALF = 2'h2;
  localparam logic [1:0] SPREAD_BAD = 2'h3;

  typedef enum logic [2:0] {
    ST_UNPOWERED,
    ST_LATCH,
    ST_WAIT_LOCK,
    ST_RUN,
    ST_POWERDOWN
  } pwr_state_t;

endpackage : clkctl_pkg

// >>> pin_sync.sv
// two-stage synchroniser for a group of pin levels
// assumes the pins are quasi-static levels, not pulses
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // pins
  input wire logic [WIDTH-1:0] i_pin,
  output logic [WIDTH-1:0] o_level
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] level;
  } sync_state_t;

  sync_state_t cur_ff;
  sync_state_t nxt_cur;

  initial
  begin
    if (WIDTH < 1) $error("pin_sync width must be positive");
  end

  // the first stage feeds only the second stage
  always_comb
  begin
    nxt_cur.meta = i_pin;
    nxt_cur.level = cur_ff.meta;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      cur_ff <= '0;
    else
      cur_ff <= nxt_cur;
  end

  assign o_level = cur_ff.level;
endmodule : pin_sync

// >>> pair_gate.sv
// glitch-free gate for one differential clock pair
// assumes i_phase is the pll output phase, one level per core cycle
`timescale 1ns/100ps
module pair_gate (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // control
  input wire logic i_run_req,
  input wire logic i_phase,
  input wire logic [1:0] i_stop_state,
  // pair outputs
  output logic o_true,
  output logic o_comp
);
  typedef struct packed {
    logic run;
    logic tru;
    logic cmp;
  } gate_state_t;

  gate_state_t cur_ff;
  gate_state_t nxt_cur;

  always_comb
  begin
    nxt_cur = cur_ff;
    // run state only rises in the low half so no runt pulse leaves the pin; a dropped request stops it at once
    if (!i_phase)
      nxt_cur.run = i_run_req;
    if (nxt_cur.run && i_run_req)
    begin
      nxt_cur.tru = i_phase;
      nxt_cur.cmp = ~i_phase;
    end
    else
    begin
      nxt_cur.run = 1'b0;
      nxt_cur.tru = i_stop_state[0];
      nxt_cur.cmp = i_stop_state[1];
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      cur_ff <= '0;
    else
      cur_ff <= nxt_cur;
  end

  assign o_true = cur_ff.tru;
  assign o_comp = cur_ff.cmp;

  stop_follow_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    !i_run_req |=> (o_true == $past(i_stop_state[0]) && o_comp == $past(i_stop_state[1])))
    else $error("stopped pair does not show stop state");
endmodule : pair_gate

// >>> clock_out_ctl.sv
// power, latch and output gating control of a four-pair reference clock generator
// assumes pll phase, crystal phase and lock come from same-clock logic;
// pins are synchronised here; registers are reached over a plain port
//
// How it works
// - first power-good high latches smbus address select
// - first power-good high captures latches, starts up
// - power-good low powers down; high leaves it
// - stop state field sets stopped pair levels
// - low-active enable pin runs each pair
// - cleared smbus enable bit disables pair
// - reference hi-z until power-up, then per bit
// - shared pin: address input, then reference copy
// - tri-level spread pin latched at power-up
// - spread from pin or register, three choices
// - pairs blocked until pll reports lock
// - pairs start or stop within three periods
// - late flag set if no lock within 300 us of release
`timescale 1ns/100ps
module clock_out_ctl
  import clkctl_pkg::*;
#(
  parameter int DRV_PD_CYCLES = DRV_PD_CYC
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // control pins
  input wire logic i_power_good_powerdown_n,
  input wire logic [NUM_PAIRS-1:0] i_pair_enable_n,
  input wire logic i_spread_tri_high,
  input wire logic i_spread_tri_mid,
  // shared address select / reference pin
  input wire logic i_bus_addr_select,
  output logic o_ref_out,
  output logic o_ref_oe,
  // pll side
  input wire logic i_pll_locked,
  input wire logic i_pll_phase,
  input wire logic i_xtal_phase,
  output logic [1:0] o_spread_sel,
  output logic o_pll_enable,
  // differential pairs
  output logic [NUM_PAIRS-1:0] o_diff_clock_pair_true,
  output logic [NUM_PAIRS-1:0] o_diff_clock_pair_comp,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic [6:0] o_smb_addr
);

  typedef struct packed {
    pwr_state_t st;
    logic [31:0] wait_cnt;
    logic late_lock;
    logic [6:0] smb_addr;
    logic [1:0] spread_pin;
    logic [NUM_PAIRS-1:0] pair_oe;
    logic [7:0] ref_cfg;
    logic [1:0] stop_state;
    logic [2:0] spread_reg;
    logic [1:0] spread_out;
    logic [NUM_PAIRS-1:0] run_req;
    logic pll_en;
    logic ref_out;
    logic ref_oe;
    logic [7:0] rdata;
  } ctl_state_t;

  ctl_state_t cur_ff;
  ctl_state_t nxt_cur;

  logic pwrgd;
  logic addr_sel;
  logic [NUM_PAIRS-1:0] pair_en_n;
  logic [1:0] spread_tri;

  initial
  begin
    if (NUM_PAIRS != 4) $error("four pairs expected");
    if (DRV_PD_CYCLES < 1) $error("drive timeout must be at least one cycle");
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  pin_sync #(.WIDTH(NUM_PAIRS + 4)) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_pin({i_power_good_powerdown_n, i_bus_addr_select, i_pair_enable_n,
            i_spread_tri_high, i_spread_tri_mid}),
    .o_level({pwrgd, addr_sel, pair_en_n, spread_tri})
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] tri_to_spread(input logic [1:0] tri_lvl);
    if (tri_lvl[1])
      return SPREAD_HALF;
    else if (tri_lvl[0])
      return SPREAD_QUARTER;
    else
      return SPREAD_OFF;
  endfunction : tri_to_spread

  function automatic logic [7:0] zext8(input logic [6:0] v);
    return {1'b0, v};
  endfunction : zext8

  // ----------------------------------------------------------------
  // control state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_cur = cur_ff;
    nxt_cur.rdata = 8'h00;

    unique case (cur_ff.st)
      ST_UNPOWERED:
      begin
        if (pwrgd)
          nxt_cur.st = ST_LATCH;
      end
      ST_LATCH:
      begin
        // shared pin still undriven here, so the sampled level is the strap
        nxt_cur.smb_addr = addr_sel ? SMB_ADDR_HIGH : SMB_ADDR_LOW;
        nxt_cur.spread_pin = tri_to_spread(spread_tri);
        nxt_cur.wait_cnt = '0;
        nxt_cur.st = ST_WAIT_LOCK;
      end
      ST_WAIT_LOCK:
      begin
        if (!pwrgd)
          nxt_cur.st = ST_POWERDOWN;
        else if (i_pll_locked)
          nxt_cur.st = ST_RUN;
        else if (cur_ff.wait_cnt == 32'(DRV_PD_CYCLES - 1))
          nxt_cur.late_lock = 1'b1;
        else
          nxt_cur.wait_cnt = cur_ff.wait_cnt + 32'h1;
      end
      ST_RUN:
      begin
        if (!pwrgd)
          nxt_cur.st = ST_POWERDOWN;
      end
      ST_POWERDOWN:
      begin
        if (pwrgd)
        begin
          nxt_cur.wait_cnt = '0;
          nxt_cur.st = ST_WAIT_LOCK;
        end
      end
    endcase

    nxt_cur.pll_en = (nxt_cur.st == ST_WAIT_LOCK) || (nxt_cur.st == ST_RUN);

    // pair run request; pin, smbus bit, power and lock all must agree
    for (int i = 0; i < NUM_PAIRS; i++)
      nxt_cur.run_req[i] = (cur_ff.st == ST_RUN) && i_pll_locked
                           && cur_ff.pair_oe[i]
                           && !pair_en_n[i];

    // shared pin: input while latching, reference copy afterwards
    nxt_cur.ref_out = 1'b0;
    nxt_cur.ref_oe = 1'b0;
    unique case (cur_ff.st)
      ST_UNPOWERED, ST_LATCH:
        nxt_cur.ref_oe = 1'b0;
      ST_POWERDOWN:
      begin
        nxt_cur.ref_oe = 1'b1;
        nxt_cur.ref_out = cur_ff.ref_cfg[REF_RUN_IN_POWERDOWN_BIT] & i_xtal_phase;
      end
      default:
      begin
        nxt_cur.ref_oe = 1'b1;
        // any cleared pair bit stops the copy unless the config bit keeps it
        if (!(&cur_ff.pair_oe) && !cur_ff.ref_cfg[REF_DIS_RUN_BIT])
          nxt_cur.ref_out = 1'b0;
        else
          nxt_cur.ref_out = i_xtal_phase;
      end
    endcase

    // spread: register override wins over the latched pin
    nxt_cur.spread_out = cur_ff.spread_reg[SPREAD_OVR_BIT] ? cur_ff.spread_reg[1:0]
                                                          : cur_ff.spread_pin;

    // register port; the host may only talk once powered up
    if (cur_ff.st != ST_UNPOWERED && cur_ff.st != ST_LATCH)
    begin
      if (i_wr)
      begin
        unique case (i_addr)
          REG_PAIR_OE: nxt_cur.pair_oe = i_wdata[NUM_PAIRS-1:0];
          REG_REF_CFG: nxt_cur.ref_cfg = i_wdata;
          REG_STOP_STATE: nxt_cur.stop_state = i_wdata[1:0];
          REG_SPREAD:
          begin
            if (i_wdata[1:0] != SPREAD_BAD)
              nxt_cur.spread_reg = i_wdata[2:0];
          end
          REG_STATUS:
          begin
            // a clear keeps only what a set in the same cycle brings, so the set wins
            if (i_wdata[7])
              nxt_cur.late_lock = (cur_ff.st == ST_WAIT_LOCK) && pwrgd && !i_pll_locked
                                  && (cur_ff.wait_cnt == 32'(DRV_PD_CYCLES - 1));
          end
          default: ;
        endcase
      end
      if (i_rd)
      begin
        unique case (i_addr)
          REG_PAIR_OE: nxt_cur.rdata = {4'h0, cur_ff.pair_oe};
          REG_REF_CFG: nxt_cur.rdata = cur_ff.ref_cfg;
          REG_STOP_STATE: nxt_cur.rdata = {6'h00, cur_ff.stop_state};
          REG_SPREAD: nxt_cur.rdata = {5'h00, cur_ff.spread_reg};
          REG_STATUS: nxt_cur.rdata = {cur_ff.late_lock, i_pll_locked, cur_ff.run_req,
                                        cur_ff.spread_out};
          REG_SMB_ADDR: nxt_cur.rdata = zext8(cur_ff.smb_addr);
          default: nxt_cur.rdata = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      cur_ff <= '0;
      cur_ff.st <= ST_UNPOWERED;
      cur_ff.smb_addr <= SMB_ADDR_LOW;
      cur_ff.pair_oe <= PAIR_OE_RST;
      cur_ff.ref_cfg <= REF_CFG_RST;
      cur_ff.stop_state <= STOP_STATE_RST;
      cur_ff.spread_reg <= SPREAD_REG_RST;
    end
    else
      cur_ff <= nxt_cur;
  end

  // ----------------------------------------------------------------
  // pair gates
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_PAIRS; g++)
  begin : g_pair
    pair_gate u_gate (
      .i_ref_clk(i_ref_clk),
      .i_srst(i_srst),
      .i_run_req(cur_ff.run_req[g]),
      .i_phase(i_pll_phase),
      .i_stop_state(cur_ff.stop_state),
      .o_true(o_diff_clock_pair_true[g]),
      .o_comp(o_diff_clock_pair_comp[g])
    );
  end

  assign o_ref_out = cur_ff.ref_out;
  assign o_ref_oe = cur_ff.ref_oe;
  assign o_spread_sel = cur_ff.spread_out;
  assign o_pll_enable = cur_ff.pll_en;
  assign o_rdata = cur_ff.rdata;
  assign o_smb_addr = cur_ff.smb_addr;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  ref_hiz_early_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (cur_ff.st == ST_UNPOWERED) |-> !o_ref_oe)
    else $error("reference driven before power-up");

  addr_latch_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (cur_ff.st == ST_LATCH) |=> (o_smb_addr == ($past(addr_sel) ? SMB_ADDR_HIGH : SMB_ADDR_LOW)))
    else $error("smbus address not latched from select pin");

  startup_seq_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (cur_ff.st == ST_UNPOWERED && pwrgd) |=> (cur_ff.st == ST_LATCH) ##1 (cur_ff.st == ST_WAIT_LOCK))
    else $error("start-up sequence skipped");

  pdown_enter_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (cur_ff.st == ST_RUN && !pwrgd) |=> (cur_ff.st == ST_POWERDOWN) ##2 (o_diff_clock_pair_true
      == {NUM_PAIRS{cur_ff.stop_state[0]}} || $changed(cur_ff.stop_state) || pwrgd))
    else $error("power-down not entered on low power-good");

  lock_block_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    !i_pll_locked |=> (cur_ff.run_req == '0))
    else $error("pair requested before pll lock");

  pin_disable_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (pair_en_n[0] || !cur_ff.pair_oe[0]) |=> !cur_ff.run_req[0])
    else $error("pair 0 runs while disabled");

  spread_legal_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_spread_sel != SPREAD_BAD)
    else $error("illegal spread code");

  ref_pdown_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (cur_ff.st == ST_POWERDOWN && !cur_ff.ref_cfg[REF_RUN_IN_POWERDOWN_BIT]) |=> !o_ref_out)
    else $error("reference runs in power-down");

  late_flag_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (cur_ff.st == ST_WAIT_LOCK && cur_ff.wait_cnt == 32'(DRV_PD_CYCLES - 1) && pwrgd
      && !i_pll_locked) |=> cur_ff.late_lock)
    else $error("late relock not flagged");
endmodule : clock_out_ctl

// >>> clkctl_pll_model.sv
// stand-in for the pll and crystal beside the clock output control block
// assumes one core clock; lock follows enable after LOCK_CYC cycles
`timescale 1ns/100ps
module clkctl_pll_model #(
  parameter int LOCK_CYC = 16
) (
  // clock
  input wire logic i_ref_clk,
  // pll side
  input wire logic i_pll_enable,
  output logic o_pll_locked,
  output logic o_pll_phase,
  output logic o_xtal_phase
);
  int cnt = 0;
  initial
  begin
    o_pll_locked = 1'b0;
    o_pll_phase = 1'b0;
    o_xtal_phase = 1'b0;
  end
  // a disabled pll loses lock at once, so every power-up must wait again
  always @(posedge i_ref_clk)
  begin
    o_xtal_phase <= ~o_xtal_phase;
    o_pll_phase <= i_pll_enable & ~o_pll_phase;
    cnt <= i_pll_enable ? cnt + 1 : 0;
    o_pll_locked <= i_pll_enable && cnt >= LOCK_CYC;
  end
endmodule : clkctl_pll_model

// >>> pcie_clock_output_control_bench.sv
// self-checking bench for clock_out_ctl
// assumes the pll stand-in locks in 16 cycles and a shortened drive timer
`timescale 1ns/100ps
module pcie_clock_output_control_bench
  import clkctl_pkg::*;
;
  // drive timer shorter than pll lock, so every power-up raises the late flag
  localparam int DRV = 12;
  logic clk, srst, pg, hi, mid, adsel, wr, rd, rd_d;
  logic [3:0] oe_n, addr, dtrue, dcomp;
  logic [7:0] wdata, rdata;
  logic ref_out, ref_oe, locked, pphase, xphase, pll_en;
  logic [1:0] spread, stop;
  logic [6:0] smb;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h00013F90;
  int num_errors = 0;
  int checks = 0;
  int p;
  logic [1:0] spr_exp[3] = '{SPREAD_OFF, SPREAD_QUARTER, SPREAD_HALF};
  logic [7:0] spr_wr[4] = '{8'h05, 8'h07, 8'h06, 8'h04};
  logic [1:0] spr_want[4] = '{SPREAD_QUARTER, SPREAD_QUARTER, SPREAD_HALF, SPREAD_OFF};

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  clkctl_pll_model #(.LOCK_CYC(16)) u_clkctl_pll_model (.i_ref_clk(clk), .i_pll_enable(pll_en),
    .o_pll_locked(locked), .o_pll_phase(pphase), .o_xtal_phase(xphase));

  clock_out_ctl #(.DRV_PD_CYCLES(DRV)) u_clock_out_ctl (.i_ref_clk(clk), .i_srst(srst),
    .i_power_good_powerdown_n(pg), .i_pair_enable_n(oe_n), .i_spread_tri_high(hi),
    .i_spread_tri_mid(mid), .i_bus_addr_select(adsel), .o_ref_out(ref_out), .o_ref_oe(ref_oe),
    .i_pll_locked(locked), .i_pll_phase(pphase), .i_xtal_phase(xphase), .o_spread_sel(spread),
    .o_pll_enable(pll_en), .o_diff_clock_pair_true(dtrue), .o_diff_clock_pair_comp(dcomp),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_smb_addr(smb));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg

  // read data stands only in the cycle after the strobe
  always @(posedge clk)
  begin
    if (rd_d)
      check("rdata", rdata, exp_q.pop_front());
    rd_d <= rd;
  end

  // sel 0..3 watches a pair as {comp,true}, sel 4 the reference as {oe,out}
  task automatic expect_out(input int sel, input logic run, input logic [1:0] lvl);
    int tg;
    logic [1:0] lv, prev;
    tg = 0;
    for (int c = 0; c < 8; c++)
    begin
      @(posedge clk);
      #1;
      lv = sel < 4 ? {dcomp[sel], dtrue[sel]} : {ref_oe, ref_out};
      if (c > 0 && lv !== prev)
        tg++;
      prev = lv;
    end
    check("toggling", {7'h00, tg > 0}, {7'h00, run});
    if (!run)
      check("held_level", {6'h00, lv}, {6'h00, lvl});
  endtask : expect_out

  task automatic power_up(input logic a, input logic h, input logic m);
    srst <= 1'b1;
    pg <= 1'b0;
    adsel <= a;
    hi <= h;
    mid <= m;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rd_reg(REG_PAIR_OE, 8'h00);
    check("ref_oe", {7'h00, ref_oe}, 8'h00);
    @(posedge clk);
    pg <= 1'b1;
    for (int n = 0; n < 20 && ref_oe !== 1'b1; n++)
      @(posedge clk);
    adsel <= ~a;
    check("pll_en", {7'h00, pll_en}, 8'h01);
  endtask : power_up

  task automatic print_verdict;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict

  initial
  begin
    repeat (5000) @(posedge clk);
    num_errors++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {srst, pg, hi, mid, adsel, wr, rd, rd_d} = 8'h80;
    oe_n = 4'h0;
    addr = 4'h0;
    wdata = 8'h00;
    for (int k = 0; k < 3; k++)
    begin
      power_up(k[0], k == 2, k == 1);
      check("smb_addr", {1'b0, smb}, {1'b0, k[0] ? SMB_ADDR_HIGH : SMB_ADDR_LOW});
      check("spread", {6'h00, spread}, {6'h00, spr_exp[k]});
      expect_out(0, 1'b0, 2'b00);
      expect_out(4, 1'b1, 2'b00);
    end
    repeat (20) @(posedge clk);
    rd_reg(REG_PAIR_OE, PAIR_OE_RST);
    rd_reg(REG_STOP_STATE, {6'h00, STOP_STATE_RST});
    rd_reg(REG_REF_CFG, REF_CFG_RST);
    rd_reg(REG_SMB_ADDR, {1'b0, SMB_ADDR_LOW});
    rd_reg(4'hE, 8'h00);
    seed = lfsr(seed);
    stop = seed[5:4];
    p = int'(seed[3:2]);
    wr_reg(REG_STOP_STATE, {6'h00, stop});
    oe_n <= 4'h1 << p;
    repeat (6) @(posedge clk);
    expect_out(p, 1'b0, stop);
    expect_out(p ^ 1, 1'b1, 2'b00);
    expect_out(4, 1'b1, 2'b00);
    wr_reg(REG_PAIR_OE, 8'h0F & ~(8'h01 << p));
    oe_n <= 4'h0;
    repeat (6) @(posedge clk);
    expect_out(p, 1'b0, stop);
    expect_out(4, 1'b0, 2'b10);
    wr_reg(REG_REF_CFG, 8'h10);
    expect_out(4, 1'b1, 2'b00);
    wr_reg(REG_PAIR_OE, PAIR_OE_RST);
    for (int k = 0; k < 4; k++)
    begin
      wr_reg(REG_SPREAD, spr_wr[k]);
      repeat (2) @(posedge clk);
      #1;
      check("spread_reg", {6'h00, spread}, {6'h00, spr_want[k]});
    end
    wr_reg(REG_REF_CFG, 8'h00);
    pg <= 1'b0;
    repeat (6) @(posedge clk);
    expect_out(p ^ 1, 1'b0, stop);
    expect_out(4, 1'b0, 2'b10);
    wr_reg(REG_REF_CFG, 8'h20);
    expect_out(4, 1'b1, 2'b00);
    @(posedge clk);
    pg <= 1'b1;
    repeat (DRV + 12) @(posedge clk);
    expect_out(p ^ 1, 1'b1, 2'b00);
    rd_reg(REG_STATUS, {2'b11, 4'hF, SPREAD_OFF});
    wr_reg(REG_STATUS, 8'h80);
    rd_reg(REG_STATUS, {2'b01, 4'hF, SPREAD_OFF});
    // let the last read data be compared before the run ends
    repeat (2) @(posedge clk);
    print_verdict();
  end
endmodule : pcie_clock_output_control_bench
